// ### src/memmap_defs.svh
// Address map constants and operation summary for the internal memory decoder
// Operation
// - 2 KB 32-bit RAM at 0x0-0x7FF
// - RAM accesses finish in one cycle
// - Empty ranges alias RAM or internal I/O
// - Alias access reaches the mirrored device
// - Unused mode: area 0 mirrors RAM, 11 bits
// - Separate 4 KB RAM, mode set by pins
// - Both pins high: additional RAM detached
// - Both pins low: expanded; mixed levels forbidden
// - Expanded: additional RAM at 0x800-0x17FF
// - Additional RAM 32-bit, one cycle
// - Expanded alias reaches only additional RAM
// - Area 2 reachable only in debug mode
`ifndef MEMMAP_DEFS_SVH
`define MEMMAP_DEFS_SVH
`define ADDR_W        28
`define RAM_WORDS     512
`define XRAM_WORDS    1024
`define RAM_TOP       28'h00007ff
`define XRAM_BASE     28'h0000800
`define XRAM_TOP      28'h00017ff
`define AREA0_TOP     28'h003ffff
`define IO_BASE       28'h0040000
`define IO_REAL_TOP   28'h004ffff
`define AREA1_TOP     28'h005ffff
`define AREA2_TOP     28'h007ffff
`define IO_ALIAS_MASK 28'h004ffff
`endif

// ### src/memmap_pkg.sv
// Types for the internal memory decoder
package memmap_pkg;
  typedef enum logic [1:0] {TGT_NONE, TGT_RAM, TGT_XRAM, TGT_IO} target_e;
  typedef enum logic [1:0] {MODE_OFF, MODE_EXP, MODE_BAD} xmode_e;
endpackage : memmap_pkg

// ### src/internal_memory_map_decoder.sv
// Internal RAM, additional RAM and mirror decoding for the on-chip bus
`timescale 1ns/1ps
`include "memmap_defs.svh"
module internal_memory_map_decoder (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [3:0]  be,
  input  wire logic [27:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        debug_mode,
  input  wire logic        extra_ram_mode_pin_hi,
  input  wire logic        extra_ram_mode_pin_lo,
  output logic             ack,
  output logic [31:0]      rdata,
  output logic             io_req,
  output logic             io_we,
  output logic [3:0]       io_be,
  output logic [27:0]      io_addr,
  output logic [31:0]      io_wdata,
  output logic             debug_area_hit,
  output logic             mode_illegal,
  output logic             expanded
);
  typedef struct packed {
    logic [2:0]                hi_sync;
    logic [2:0]                lo_sync;
    memmap_pkg::xmode_e        mode;
    logic                      ack;
    logic [31:0]               rdata;
    logic                      io_req;
    logic                      io_we;
    logic [3:0]                io_be;
    logic [27:0]               io_addr;
    logic [31:0]               io_wdata;
    logic                      dbg_hit;
    logic                      exp_mode;
    logic                      bad_mode;
  } state_s;

  state_s st;
  state_s next_st;
  logic [31:0] ram  [0:`RAM_WORDS-1];
  logic [31:0] xram [0:`XRAM_WORDS-1];

  memmap_pkg::target_e tgt;
  logic [8:0]  ram_idx;
  logic [9:0]  xram_idx;
  logic [27:0] xoff;
  logic        dbg_area;

  // Byte-lane merge, used for both RAM arrays
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] lanes);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Inclusive address window test, shared by the area decode
  function automatic logic in_span(input logic [27:0] a, input logic [27:0] lo,
                                   input logic [27:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_span

  always_comb begin
    xoff     = addr - `XRAM_BASE;
    ram_idx  = addr[10:2];
    xram_idx = xoff[11:2];
    dbg_area = in_span(addr, `AREA1_TOP + 28'h1, `AREA2_TOP);
    tgt      = memmap_pkg::TGT_NONE;
    if (addr <= `AREA0_TOP) begin
      if (addr <= `RAM_TOP) begin
        tgt = memmap_pkg::TGT_RAM;
      end else if (st.mode == memmap_pkg::MODE_EXP) begin
        tgt = memmap_pkg::TGT_XRAM;
      end else if (st.mode == memmap_pkg::MODE_OFF) begin
        tgt = memmap_pkg::TGT_RAM;
      end
    end else if (in_span(addr, `IO_BASE, `AREA1_TOP)) begin
      tgt = memmap_pkg::TGT_IO;
    end
  end

  always_comb begin
    next_st         = st;
    next_st.hi_sync = {st.hi_sync[1:0], extra_ram_mode_pin_hi};
    next_st.lo_sync = {st.lo_sync[1:0], extra_ram_mode_pin_lo};
    // Mode only moves once two later stages agree; pins should not move mid-access
    if (st.hi_sync[2] == st.hi_sync[1] && st.lo_sync[2] == st.lo_sync[1]) begin
      if (st.hi_sync[1] && st.lo_sync[1]) begin
        next_st.mode = memmap_pkg::MODE_OFF;
      end else if (!st.hi_sync[1] && !st.lo_sync[1]) begin
        next_st.mode = memmap_pkg::MODE_EXP;
      end else begin
        next_st.mode = memmap_pkg::MODE_BAD;
      end
    end
    // Flags copied into flops so the mode outputs carry no decode logic
    next_st.exp_mode = (next_st.mode == memmap_pkg::MODE_EXP);
    next_st.bad_mode = (next_st.mode == memmap_pkg::MODE_BAD);
    next_st.ack     = 1'b0;
    next_st.io_req  = 1'b0;
    next_st.dbg_hit = 1'b0;
    next_st.rdata   = 32'h0;
    if (req) begin
      unique case (tgt)
        memmap_pkg::TGT_RAM: begin
          next_st.ack   = 1'b1;
          next_st.rdata = ram[ram_idx];
        end
        memmap_pkg::TGT_XRAM: begin
          next_st.ack   = 1'b1;
          next_st.rdata = xram[xram_idx];
        end
        memmap_pkg::TGT_IO: begin
          // Mirror folds onto the real I/O block
          next_st.io_req   = 1'b1;
          next_st.io_we    = we;
          next_st.io_be    = be;
          next_st.io_addr  = addr & `IO_ALIAS_MASK;
          next_st.io_wdata = wdata;
        end
        memmap_pkg::TGT_NONE: begin
          // Illegal mode and unreached areas still answer so the bus never hangs
          next_st.ack     = 1'b1;
          next_st.dbg_hit = dbg_area && !debug_mode;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st      <= '0;
      // Chains start at the detached level so no false mode follows reset
      st.hi_sync <= 3'b111;
      st.lo_sync <= 3'b111;
      st.mode    <= memmap_pkg::MODE_OFF;
    end else begin
      st <= next_st;
    end
  end

  // Arrays written outside the reset; RAM content is undefined after reset
  always_ff @(posedge clk) begin
    if (!reset && req && we && tgt == memmap_pkg::TGT_RAM) begin
      ram[ram_idx] <= merge(ram[ram_idx], wdata, be);
    end
    if (!reset && req && we && tgt == memmap_pkg::TGT_XRAM) begin
      xram[xram_idx] <= merge(xram[xram_idx], wdata, be);
    end
  end

  assign ack            = st.ack;
  assign rdata          = st.rdata;
  assign io_req         = st.io_req;
  assign io_we          = st.io_we;
  assign io_be          = st.io_be;
  assign io_addr        = st.io_addr;
  assign io_wdata       = st.io_wdata;
  assign debug_area_hit = st.dbg_hit;
  assign mode_illegal   = st.bad_mode;
  assign expanded       = st.exp_mode;

  ram_one_cycle_a: assert property (@(posedge clk) disable iff (reset)
    req && addr <= `RAM_TOP |=> ack) else $error("RAM access not answered in one cycle");
  xram_one_cycle_a: assert property (@(posedge clk) disable iff (reset)
    req && expanded && addr > `RAM_TOP && addr <= `AREA0_TOP |=> ack)
    else $error("Additional RAM access not answered in one cycle");
  io_mirror_fold_a: assert property (@(posedge clk) disable iff (reset)
    req && addr > `IO_REAL_TOP && addr <= `AREA1_TOP
    |=> io_req && io_addr == $past(addr) - 28'h10000)
    else $error("I/O mirror not folded");
  user_area2_a: assert property (@(posedge clk) disable iff (reset)
    req && !debug_mode && addr > `AREA1_TOP && addr <= `AREA2_TOP |=> ack && debug_area_hit && !io_req)
    else $error("User access to debug area mishandled");
  mode_exp_a: assert property (@(posedge clk) disable iff (reset)
    (!extra_ram_mode_pin_hi && !extra_ram_mode_pin_lo)[*5] |-> expanded)
    else $error("Expanded mode not entered");
  mode_off_a: assert property (@(posedge clk) disable iff (reset)
    (extra_ram_mode_pin_hi && extra_ram_mode_pin_lo)[*5] |-> !expanded && !mode_illegal)
    else $error("Detached mode not entered");
  ram_mirror_a: assert property (@(posedge clk) disable iff (reset)
    req && !we && !expanded && !mode_illegal && addr <= `AREA0_TOP && $stable(mode_illegal)
    ##1 req && we && addr[10:0] == $past(addr[10:0]) && be == 4'hf && addr <= `AREA0_TOP
    ##1 req && !we && addr == $past(addr, 2) |=> rdata == $past(wdata, 2))
    else $error("RAM mirror does not reach the same word");
  area0_no_io_a: assert property (@(posedge clk) disable iff (reset)
    req && addr <= `AREA0_TOP |=> !io_req) else $error("Area 0 leaked to I/O");

  // Answers that must stay quiet or inert, and the flag for mixed pin levels
  idle_quiet_a: assert property (@(posedge clk) disable iff (reset)
    !req |=> !ack && !io_req && rdata == 32'h0)
    else $error("Answer without a request");
  io_no_ack_a: assert property (@(posedge clk) disable iff (reset)
    req && addr >= `IO_BASE && addr <= `AREA1_TOP |=> io_req && !ack && rdata == 32'h0)
    else $error("I/O access answered locally");
  user_area2_quiet_a: assert property (@(posedge clk) disable iff (reset)
    req && !debug_mode && addr > `AREA1_TOP && addr <= `AREA2_TOP |=> rdata == 32'h0)
    else $error("User access to debug area returned data");
  debug_area2_a: assert property (@(posedge clk) disable iff (reset)
    req && debug_mode && addr > `AREA1_TOP && addr <= `AREA2_TOP |=> ack && !debug_area_hit)
    else $error("Debug access to area 2 flagged");
  illegal_inert_a: assert property (@(posedge clk) disable iff (reset)
    req && mode_illegal && addr > `RAM_TOP && addr <= `AREA0_TOP |=> ack && rdata == 32'h0)
    else $error("Illegal mode access not inert");
  mode_bad_a: assert property (@(posedge clk) disable iff (reset)
    (extra_ram_mode_pin_hi != extra_ram_mode_pin_lo)[*5] |-> mode_illegal && !expanded)
    else $error("Mixed pin levels not flagged");
  // Back-to-back alias traffic must land on the word that it mirrors
  xram_alias_a: assert property (@(posedge clk) disable iff (reset)
    req && !we && expanded && addr > `RAM_TOP && addr <= `AREA0_TOP
    ##1 req && we && be == 4'hf && addr > `RAM_TOP && addr <= `AREA0_TOP
    && addr[11:0] == $past(addr[11:0])
    ##1 req && !we && addr == $past(addr, 2) |=> rdata == $past(wdata, 2))
    else $error("Additional RAM alias does not reach the same word");
endmodule : internal_memory_map_decoder

// ### tb/bus_master.sv
// Bus master model: one access at a time on the internal bus
`timescale 1ns/1ps
module bus_master (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  output logic             req,
  output logic             we,
  output logic [3:0]       be,
  output logic [27:0]      addr,
  output logic [31:0]      wdata
);
  initial begin
    {req, we, be, addr, wdata} = '0;
  end
  task automatic xfer(input logic w, input logic [3:0] b, input logic [27:0] a,
                      input logic [31:0] d, output logic ak, output logic [31:0] rd);
    @(posedge clk);
    {req, we, be, addr, wdata} <= {1'b1, w, b, a, d};
    @(posedge clk);
    // Idle lines flip so a stale address can never look valid
    {req, we, addr, wdata} <= {1'b0, ~w, ~a, ~d};
    #1;
    ak = ack;
    rd = rdata;
  endtask : xfer
  // Read, write to a mirror of the same word, read again on three back-to-back cycles
  task automatic trio(input logic [27:0] a, input logic [27:0] b, input logic [31:0] d,
                      output logic [31:0] rd);
    @(posedge clk);
    {req, we, be, addr, wdata} <= {1'b1, 1'b0, 4'hf, a, 32'h0};
    @(posedge clk);
    {req, we, be, addr, wdata} <= {1'b1, 1'b1, 4'hf, b, d};
    @(posedge clk);
    {req, we, be, addr, wdata} <= {1'b1, 1'b0, 4'hf, a, 32'h0};
    @(posedge clk);
    {req, we, addr, wdata} <= {1'b0, 1'b1, ~a, ~d};
    #1;
    rd = rdata;
  endtask : trio
endmodule : bus_master

// ### tb/testbench.sv
// Self-checking bench for the internal memory decoder
`timescale 1ns/1ps
`include "memmap_defs.svh"
module testbench;
  logic        clk = 1'b0, reset = 1'b1, debug_mode = 1'b0, xm = 1'b0, ak;
  logic        extra_ram_mode_pin_hi = 1'b1, extra_ram_mode_pin_lo = 1'b1;
  logic        req, we, ack, io_req, io_we, debug_area_hit, mode_illegal, expanded;
  logic [3:0]  be, io_be;
  logic [27:0] addr, io_addr;
  logic [31:0] wdata, rdata, io_wdata, r, w;
  logic [31:0] mem [1536];
  int          miscompares = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  internal_memory_map_decoder internal_memory_map_decoder_i (.clk(clk), .reset(reset),
    .req(req), .we(we), .be(be), .addr(addr), .wdata(wdata), .debug_mode(debug_mode),
    .extra_ram_mode_pin_hi(extra_ram_mode_pin_hi), .extra_ram_mode_pin_lo(extra_ram_mode_pin_lo),
    .ack(ack), .rdata(rdata), .io_req(io_req), .io_we(io_we), .io_be(io_be), .io_addr(io_addr),
    .io_wdata(io_wdata), .debug_area_hit(debug_area_hit), .mode_illegal(mode_illegal),
    .expanded(expanded));
  bus_master bus_master_i (.clk(clk), .ack(ack), .rdata(rdata), .req(req), .we(we), .be(be),
    .addr(addr), .wdata(wdata));
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task check(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : check
  // Flat model: RAM words 0..511, additional RAM 512..1535
  function automatic int slot(input logic [27:0] a, input logic x);
    if (a <= `RAM_TOP || !x)
      return int'(a[10:2]);
    return 512 + int'(((a - `XRAM_BASE) & 28'hfff) >> 2);
  endfunction : slot
  function automatic logic [27:0] base(input logic [11:0] o, input logic [5:0] k);
    if (xm)
      return `XRAM_BASE + {16'h0, o[11:2], 2'b00} + {10'h0, k, 12'h0};
    return {17'h0, o[10:2], 2'b00} + {11'h0, k, 11'h0};
  endfunction : base
  task automatic wr(input logic [27:0] a, input logic [31:0] d);
    bus_master_i.xfer(1'b1, 4'hf, a, d, ak, r);
    check(ak === 1'b1, "write ack");
    mem[slot(a, xm)] = d;
  endtask : wr
  task automatic rd(input logic [27:0] a);
    bus_master_i.xfer(1'b0, 4'hf, a, 32'h0, ak, r);
    check(ak === 1'b1 && r === mem[slot(a, xm)], "read data");
  endtask : rd
  task automatic sweep();
    logic [11:0] o;
    for (int i = 0; i < 24; i++) begin
      o = 12'($urandom);
      wr(base(o, 6'($urandom_range(62))), $urandom);
      rd(base(o, 6'($urandom_range(62))));
    end
  endtask : sweep
  // Pins move only while the bus is idle
  task automatic pins(input logic h, input logic l);
    @(posedge clk);
    extra_ram_mode_pin_hi <= h;
    extra_ram_mode_pin_lo <= l;
    repeat (8) @(posedge clk);
    #1 check(expanded === (!h && !l) && mode_illegal === (h ^ l), "mode flags");
    xm = !h && !l;
  endtask : pins
  initial begin
    void'($urandom(32'hf246));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1 check({ack, io_req, debug_area_hit, expanded} === 4'h0, "reset outputs");
    sweep();
    wr(28'h3fffc, 32'hc0ffee01);
    rd(28'h7fc);
    bus_master_i.xfer(1'b1, 4'h2, 28'h7fc, 32'h0000ab00, ak, r);
    mem[511][15:8] = 8'hab;
    rd(28'h7fc);
    w = $urandom;
    bus_master_i.trio(28'h1f4, 28'h3f1f4, w, r);
    check(r === w, "mirror read after write");
    mem[slot(28'h1f4, xm)] = w;
    bus_master_i.xfer(1'b1, 4'h3, 28'h50004, 32'h12345678, ak, r);
    check(ak === 1'b0 && io_req === 1'b1 && {io_we, io_be, io_addr, io_wdata} ===
          {1'b1, 4'h3, 28'h40004, 32'h12345678}, "io mirror");
    bus_master_i.xfer(1'b0, 4'hf, 28'h60000, 32'h0, ak, r);
    check(ak === 1'b1 && debug_area_hit === 1'b1 && r === 32'h0, "user area2");
    @(posedge clk);
    debug_mode <= 1'b1;
    bus_master_i.xfer(1'b0, 4'hf, 28'h7fffc, 32'h0, ak, r);
    check(ak === 1'b1 && debug_area_hit === 1'b0, "debug area2");
    pins(1'b0, 1'b0);
    sweep();
    wr(28'h10, 32'h5a5a0010);
    wr(28'h1010, 32'ha5a51010);
    rd(28'h2010);
    rd(28'h10);
    w = $urandom;
    bus_master_i.trio(28'h810, 28'h1810, w, r);
    check(r === w, "alias read after write");
    mem[slot(28'h810, xm)] = w;
    pins(1'b1, 1'b0);
    bus_master_i.xfer(1'b0, 4'hf, 28'h900, 32'h0, ak, r);
    check(ak === 1'b1 && r === 32'h0, "illegal mode inert");
    conclude();
  end
  initial begin
    #200us;
    miscompares++;
    conclude();
  end
endmodule : testbench
